// >>> isr_map.vh
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ISR_BUS_CONTROL_REG 4'h0
`define ISR_BUS_STATUS_REG 4'h1
`define ISR_BUS_FLAG_REG 4'h2
`define ISR_CLOCK_SELECT_REG 4'h3
`define ISR_CLOCK_EXTENSION_REG 4'h4
`define ISR_OWN_ADDRESS_REG 4'h5
`define ISR_SHIFT_DATA_REG 4'h6
// ----------------------------------------------------------------------
// bus_control_reg fields
// ----------------------------------------------------------------------
`define ISR_CTL_ENABLE 7
`define ISR_CTL_LEAVE 6
`define ISR_CTL_WAIT_REL 5
`define ISR_CTL_STOP_IRQ 4
`define ISR_CTL_START 1
`define ISR_CTL_STOP 0
// ----------------------------------------------------------------------
// bus_status_reg fields
// ----------------------------------------------------------------------
`define ISR_STS_MASTER 7
`define ISR_STS_EXT 5
`define ISR_STS_MATCH 4
`define ISR_STS_START_DET 1
`define ISR_STS_STOP_DET 0
// ----------------------------------------------------------------------
// bus_flag_reg fields
// ----------------------------------------------------------------------
`define ISR_FLG_START_FAIL 7
`define ISR_FLG_BUSY 6
`define ISR_FLG_NO_STOP 1
`define ISR_FLG_RSV_DIS 0
// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define ISR_RST_BYTE 8'h00
`define ISR_EXT_LOW 4'h0
`define ISR_EXT_HIGH 4'hf
`endif

// >>> isr_sync.v
`timescale 1ns/10ps
module isr_sync (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Pins
  input wire scl_in,
  input wire sda_in,
  // Synchronised levels
  output reg scl_s,
  output reg sda_s
);
  reg scl_m;
  reg sda_m;
  // Second stage alone feeds logic, resets to idle-high
  always @(posedge sys_clk) begin
    if (srst) begin
      scl_m <= 1'b1;
      sda_m <= 1'b1;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
    end else begin
      scl_m <= scl_in;
      sda_m <= sda_in;
      scl_s <= scl_m;
      sda_s <= sda_m;
    end
  end
endmodule

// >>> isr_clkdiv.v
`timescale 1ns/10ps
module isr_clkdiv (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Divider select
  input wire [1:0] div_sel,
  // Enable pulse at the selected rate
  output reg tick
);
  reg [1:0] cnt_reg;
  reg [1:0] lim;
  always @* begin
    case (div_sel)
      2'h2: lim = 2'h0;
      2'h3: lim = 2'h2;
      default: lim = 2'h1;
    endcase
  end
  always @(posedge sys_clk) begin
    if (srst) begin
      cnt_reg <= 2'h0;
      tick <= 1'b0;
    end else if (cnt_reg >= lim) begin
      cnt_reg <= 2'h0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      tick <= 1'b0;
    end
  end
endmodule

// >>> isr_top.v
`timescale 1ns/10ps
`include "isr_map.vh"
// Overview of operation
// - Slave events interrupt only on own address or extension code.
// - Start detection enters wakeup standby held through the address byte.
// - Stop interrupt depends only on stop_irq_enable.
// - Reservation enabled: pending start issued after stop releases bus.
// - Bus unused when neither master nor slave, or after leave release.
// - Data writes during a pending reservation before stop are ignored.
// - Start request resolves to immediate start or reservation by bus state.
// - Reservation accepted between start detection and the following stop, except while addressed as slave.
// - Reservation disabled: request on foreign busy bus is rejected.
// - Rejected start shows in start_fail_flag after a short wait.
// - Without start_without_stop_enable, busy reads 1 after enabling.
// - With start_without_stop_enable, bus assumed free after enabling.
// - Reserved transfer waits; data write moves wait on to send, SCL stays held.
// - master_state_flag updates for polling without stop interrupt.
// - After stop release, writing slave address starts master transfer.
// - Upper nibble 0000 or 1111 sets extension flag at ninth SCL fall after start (end of eighth bit).
// - Received address compared with own_address_reg raises interrupt.
module isr_top (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // Bus pins
  input wire scl_in,
  input wire sda_in,
  output reg scl_out,
  output reg scl_oe,
  output reg sda_out,
  output reg sda_oe,
  // Event
  output reg bus_event_irq
);
  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam ST_IDLE = 6'h01;
  localparam ST_ADDR = 6'h02;
  localparam ST_SLAVE = 6'h04;
  localparam ST_RSV = 6'h08;
  localparam ST_MWAIT = 6'h10;
  localparam ST_MSEND = 6'h20;

  function is_ext;
    input [7:0] a;
    begin
      is_ext = (a[7:4] == `ISR_EXT_LOW) || (a[7:4] == `ISR_EXT_HIGH);
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchroniser and divider
  // --------------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  wire tick;
  reg [7:0] clock_select_reg;
  reg [7:0] clock_extension_reg;
  isr_sync u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_s(scl_s),
    .sda_s(sda_s)
  );
  isr_clkdiv u_div (
    .sys_clk(sys_clk),
    .srst(srst),
    .div_sel(clock_select_reg[1:0]),
    .tick(tick)
  );

  // --------------------------------------------------------------------
  // Line edge detection
  // --------------------------------------------------------------------
  reg scl_d;
  reg sda_d;
  always @(posedge sys_clk) begin
    if (srst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  wire start_ev = scl_s && scl_d && sda_d && !sda_s;
  wire stop_ev = scl_s && scl_d && !sda_d && sda_s;
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg [7:0] bus_control_reg;
  reg [7:0] own_address_reg;
  reg [7:0] shift_data_reg;
  reg reserve_disable;
  reg start_without_stop_enable;
  reg start_fail_flag;
  reg bus_busy_flag;
  reg master_state_flag;
  reg extension_code_flag;
  reg match_flag;
  reg start_detected_flag;
  reg stop_detected_flag;
  reg [5:0] state_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] rx_reg;
  reg send_go_reg;
  wire i2c_operate_enable = bus_control_reg[`ISR_CTL_ENABLE];
  wire stop_irq_enable = bus_control_reg[`ISR_CTL_STOP_IRQ];
  wire wr_ctl = reg_wr && (reg_addr == `ISR_BUS_CONTROL_REG);
  wire start_request = wr_ctl && reg_wdata[`ISR_CTL_START] &&
    !bus_control_reg[`ISR_CTL_START];
  wire stop_request = wr_ctl && reg_wdata[`ISR_CTL_STOP];
  wire leave_comm_release = wr_ctl && reg_wdata[`ISR_CTL_LEAVE];
  wire wr_data = reg_wr && (reg_addr == `ISR_SHIFT_DATA_REG);
  // Bus unused by us: not master and not addressed slave
  wire not_using = (state_reg == ST_IDLE) || (state_reg == ST_ADDR);
  wire data_ok = !(state_reg == ST_RSV);

  always @(posedge sys_clk) begin
    if (srst) begin
      bus_control_reg <= `ISR_RST_BYTE;
      own_address_reg <= `ISR_RST_BYTE;
      clock_select_reg <= `ISR_RST_BYTE;
      clock_extension_reg <= `ISR_RST_BYTE;
      shift_data_reg <= `ISR_RST_BYTE;
      reserve_disable <= 1'b0;
      start_without_stop_enable <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ISR_BUS_CONTROL_REG: bus_control_reg <= reg_wdata;
        `ISR_OWN_ADDRESS_REG: own_address_reg <= reg_wdata;
        // Clock selection only changes while disabled
        `ISR_CLOCK_SELECT_REG: begin
          if (!i2c_operate_enable) clock_select_reg <= reg_wdata;
        end
        `ISR_CLOCK_EXTENSION_REG: begin
          if (!i2c_operate_enable) clock_extension_reg <= reg_wdata;
        end
        `ISR_BUS_FLAG_REG: begin
          reserve_disable <= reg_wdata[`ISR_FLG_RSV_DIS];
          start_without_stop_enable <= reg_wdata[`ISR_FLG_NO_STOP];
        end
        `ISR_SHIFT_DATA_REG: begin
          if (data_ok) shift_data_reg <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Protocol state machine
  // --------------------------------------------------------------------
  reg [5:0] state_next;
  reg irq_next;
  wire addr_done = (state_reg == ST_ADDR) && scl_fall && (bit_cnt_reg == 4'h8);
  wire rx_match = (rx_reg[7:1] == own_address_reg[7:1]);
  always @* begin
    state_next = state_reg;
    irq_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (start_ev) state_next = ST_ADDR;
        if (start_request && !bus_busy_flag) state_next = ST_MSEND;
      end
      ST_ADDR: begin
        if (addr_done) begin
          if (rx_match || is_ext(rx_reg)) begin
            state_next = ST_SLAVE;
            irq_next = 1'b1;
          end else begin
            state_next = ST_IDLE;
          end
        end
        // Reservation window: after start detected, before stop
        if (start_request && !reserve_disable) state_next = ST_RSV;
      end
      ST_SLAVE: begin
        if (leave_comm_release) state_next = ST_IDLE;
      end
      ST_RSV: begin
        if (stop_ev) state_next = ST_MWAIT;
      end
      ST_MWAIT: begin
        if (wr_data) state_next = ST_MSEND;
      end
      ST_MSEND: begin
        if (stop_request) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (stop_ev && stop_irq_enable) irq_next = 1'b1;
    if (start_ev && state_reg == ST_SLAVE) state_next = ST_ADDR;
    if (stop_ev && state_reg != ST_RSV) state_next = ST_IDLE;
    if (state_reg == ST_IDLE && start_request && bus_busy_flag &&
        !reserve_disable) state_next = ST_RSV;
    if (!i2c_operate_enable) state_next = ST_IDLE;
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      bus_event_irq <= 1'b0;
      start_fail_flag <= 1'b0;
      bus_busy_flag <= 1'b1;
      master_state_flag <= 1'b0;
      extension_code_flag <= 1'b0;
      match_flag <= 1'b0;
      start_detected_flag <= 1'b0;
      stop_detected_flag <= 1'b0;
      send_go_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bus_event_irq <= irq_next;
      if (start_ev) begin
        bit_cnt_reg <= 4'h0;
        start_detected_flag <= 1'b1;
        stop_detected_flag <= 1'b0;
        extension_code_flag <= 1'b0;
        match_flag <= 1'b0;
      end else if (scl_rise && bit_cnt_reg < 4'h8) begin
        // Count rises, not falls: the fall right after start holds no bit
        rx_reg <= {rx_reg[6:0], sda_s};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (addr_done) begin
        extension_code_flag <= is_ext(rx_reg);
        match_flag <= rx_match;
      end
      if (stop_ev) begin
        stop_detected_flag <= 1'b1;
        start_detected_flag <= 1'b0;
      end
      // Busy level follows the line, enable sets the assumed start point
      if (wr_ctl && reg_wdata[`ISR_CTL_ENABLE] && !i2c_operate_enable)
        bus_busy_flag <= !start_without_stop_enable;
      else if (start_ev)
        bus_busy_flag <= 1'b1;
      else if (stop_ev)
        bus_busy_flag <= 1'b0;
      // Set wins over clear: a rejection in the write cycle stands
      if (start_request && reserve_disable && bus_busy_flag && not_using)
        start_fail_flag <= 1'b1;
      else if (start_request)
        start_fail_flag <= 1'b0;
      master_state_flag <= (state_next == ST_MSEND) ||
        (state_next == ST_MWAIT);
      if (tick) send_go_reg <= (state_reg == ST_MSEND);
    end
  end

  // --------------------------------------------------------------------
  // Pin drive: start generation, wait hold while reserved
  // --------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      // Start pulls SDA low; SCL held low in wait and still held in send after data written
      sda_oe <= (state_reg == ST_MWAIT) || (state_reg == ST_MSEND);
      // SCL follows SDA by a cycle so the pair forms a real start
      scl_oe <= ((state_reg == ST_MWAIT) && sda_oe) ||
        ((state_reg == ST_MSEND) && scl_oe) || send_go_reg;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Read port, data one cycle after strobe
  // --------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ISR_BUS_CONTROL_REG: reg_rdata <= bus_control_reg;
        `ISR_BUS_STATUS_REG: reg_rdata <= {master_state_flag, 1'b0,
          extension_code_flag, match_flag, 2'b00, start_detected_flag,
          stop_detected_flag};
        `ISR_BUS_FLAG_REG: reg_rdata <= {start_fail_flag, bus_busy_flag,
          4'h0, start_without_stop_enable, reserve_disable};
        `ISR_CLOCK_SELECT_REG: reg_rdata <= clock_select_reg;
        `ISR_CLOCK_EXTENSION_REG: reg_rdata <= clock_extension_reg;
        `ISR_OWN_ADDRESS_REG: reg_rdata <= own_address_reg;
        `ISR_SHIFT_DATA_REG: reg_rdata <= shift_data_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// >>> isr_chk.sv
`timescale 1ns/10ps
`include "isr_map.vh"
module isr_chk (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  // Bus pins
  input wire scl_in,
  input wire sda_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_out,
  input wire sda_oe,
  // Event
  input wire bus_event_irq
);
  reg [3:0] quiet_reg;
  reg scl_d_reg;
  reg sda_d_reg;
  reg fresh_reg;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  // Interrupts must follow a pin event; a silent bus never wakes us
  always @(posedge sys_clk) begin
    scl_d_reg <= scl_in;
    sda_d_reg <= sda_in;
    if (srst)
      quiet_reg <= 4'hf;
    else if (scl_in != scl_d_reg || sda_in != sda_d_reg)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf)
      quiet_reg <= quiet_reg + 4'h1;
    if (srst)
      fresh_reg <= 1'b1;
    else if (reg_wr)
      fresh_reg <= 1'b0;
  end
  sequence master_start_s;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence master_wait_s;
    sda_oe throughout (##[1:40] scl_oe);
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  irq_cause_a: assert property (bus_event_irq |-> quiet_reg < 4'h8)
    else $error("event pulse without a pin event");
  irq_pulse_a: assert property (bus_event_irq |=> !bus_event_irq)
    else $error("event pulse longer than one cycle");
  start_wait_a: assert property (master_start_s |-> master_wait_s)
    else $error("start not followed by clock hold");
  wait_start_a: assert property ($rose(scl_oe) |-> sda_oe)
    else $error("clock held without start");
  busy_reset_a: assert property (fresh_reg && reg_rd &&
    reg_addr == `ISR_BUS_FLAG_REG |=> reg_rdata[`ISR_FLG_BUSY])
    else $error("busy flag clear after reset");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 4'h6 |=>
    reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin output level not low");
  reset_quiet_a: assert property (@(posedge sys_clk) disable iff (1'b0)
    srst |=> !scl_oe && !sda_oe && !bus_event_irq && reg_rdata == 8'h00)
    else $error("outputs active after reset");
endmodule
bind isr_top isr_chk chk_u (.sys_clk(sys_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in), .sda_in(sda_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
  .bus_event_irq(bus_event_irq));

// >>> isr_agent.sv
`timescale 1ns/10ps
module isr_agent (
  // Device pull-downs
  scl_oe,
  sda_oe,
  // Wired lines
  scl_line,
  sda_line
);
  input wire scl_oe;
  input wire sda_oe;
  output wire scl_line;
  output wire sda_line;
  reg scl_drv = 1'b1;
  reg sda_drv = 1'b1;
  integer i;
  // Open drain with pull-ups: any party pulling low wins
  assign scl_line = scl_drv & ~scl_oe;
  assign sda_line = sda_drv & ~sda_oe;
  task start_c;
    begin
      sda_drv = 1'b0;
      #400 scl_drv = 1'b0;
    end
  endtask
  task put_bit(input reg b);
    begin
      sda_drv = b;
      #200 scl_drv = 1'b1;
      i = 0;
      // Clock may be stretched low by the other side
      while (scl_line !== 1'b1 && i < 100) begin
        #100 i = i + 1;
      end
      #400 scl_drv = 1'b0;
      // Data stays put until the next bit sets it, one change per bit
      #200;
    end
  endtask
  task put_byte(input reg [7:0] d);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1)
        put_bit(d[k]);
      put_bit(1'b1);
    end
  endtask
  task stop_c;
    begin
      sda_drv = 1'b0;
      #200 scl_drv = 1'b1;
      #400 sda_drv = 1'b1;
      #400;
    end
  endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
`include "isr_map.vh"
module tb_top;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire scl_line, sda_line, scl_out, scl_oe, sda_out, sda_oe, bus_event_irq;
  integer n_mismatch = 0;
  integer tests_run = 0;
  integer irq_cnt = 0;
  integer base, k, w;
  reg [7:0] own, adr;
  reg [7:0] tbl [0:3];
  initial forever #50 sys_clk = ~sys_clk;
  always @(negedge sys_clk) if (bus_event_irq === 1'b1) irq_cnt = irq_cnt + 1;
  isr_top dut_u (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl_line), .sda_in(sda_line),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe), .bus_event_irq(bus_event_irq));
  isr_agent agent_u (.scl_oe(scl_oe), .sda_oe(sda_oe),
    .scl_line(scl_line), .sda_line(sda_line));
  // ------------------------------------------------------------
  // Model and bus tasks
  // ------------------------------------------------------------
  function integer exp_irq(input [7:0] a, input [7:0] o, input s);
    exp_irq = ((a[7:1] == o[7:1] || a[7:4] == 4'h0 || a[7:4] == 4'hf)
      ? 1 : 0) + (s ? 1 : 0);
  endfunction
  task check(input [7:0] got, input [7:0] exp, input [7:0] m);
    begin
      tests_run = tests_run + 1;
      if ((got & m) !== (exp & m)) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk) reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [7:0] e, input [7:0] m);
    begin
      @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 check(reg_rdata, e, m);
    end
  endtask
  task tally_and_finish;
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #2000000 n_mismatch = n_mismatch + 1;
    $display("Error at %0t: run timed out", $time);
    tally_and_finish;
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'he32e2d2c));
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    rd(`ISR_BUS_FLAG_REG, 8'h40, 8'hff);
    rd(`ISR_BUS_STATUS_REG, 8'h00, 8'hff);
    rd(4'hf, 8'h00, 8'hff);
    $display("test 1 done");
    wr(`ISR_CLOCK_SELECT_REG, 8'h00);
    wr(`ISR_BUS_FLAG_REG, 8'h02);
    wr(`ISR_BUS_CONTROL_REG, 8'h80);
    rd(`ISR_BUS_FLAG_REG, 8'h02, 8'h42);
    wr(`ISR_BUS_CONTROL_REG, 8'h00);
    wr(`ISR_BUS_FLAG_REG, 8'h00);
    wr(`ISR_BUS_CONTROL_REG, 8'h80);
    rd(`ISR_BUS_FLAG_REG, 8'h40, 8'h42);
    $display("test 2 done");
    own = {4'(4'h1 + $urandom % 14), 3'($urandom), 1'b0};
    wr(`ISR_OWN_ADDRESS_REG, own);
    tbl[0] = own | 8'($urandom % 2);
    tbl[1] = 8'($urandom % 16);
    tbl[2] = 8'hf0 | 8'($urandom % 16);
    tbl[3] = own ^ 8'h02;
    for (k = 0; k < 4; k = k + 1) begin
      wr(`ISR_BUS_CONTROL_REG, 8'h80 | (k[0] ? 8'h10 : 8'h00));
      base = irq_cnt;
      #37 agent_u.start_c;
      agent_u.put_byte(tbl[k]);
      agent_u.stop_c;
      repeat (10) @(posedge sys_clk);
      w = irq_cnt - base;
      check(w[7:0], exp_irq(tbl[k], own, k[0]), 8'hff);
    end
    $display("test 3 done");
    wr(`ISR_BUS_CONTROL_REG, 8'h00);
    wr(`ISR_BUS_FLAG_REG, 8'h01);
    wr(`ISR_BUS_CONTROL_REG, 8'h90);
    #37 agent_u.start_c;
    wr(`ISR_BUS_CONTROL_REG, 8'h92);
    repeat (20) @(posedge sys_clk);
    rd(`ISR_BUS_FLAG_REG, 8'h80, 8'h80);
    rd(`ISR_BUS_STATUS_REG, 8'h00, 8'h80);
    wr(`ISR_BUS_CONTROL_REG, 8'h90);
    agent_u.put_byte(own ^ 8'h02);
    agent_u.stop_c;
    repeat (30) @(posedge sys_clk);
    check({7'h00, sda_oe}, 8'h00, 8'h01);
    $display("test 4 done");
    wr(`ISR_BUS_CONTROL_REG, 8'h00);
    wr(`ISR_BUS_FLAG_REG, 8'h00);
    wr(`ISR_BUS_CONTROL_REG, 8'h90);
    #37 agent_u.start_c;
    wr(`ISR_BUS_CONTROL_REG, 8'h92);
    repeat (46) @(posedge sys_clk);
    rd(`ISR_BUS_STATUS_REG, 8'h00, 8'h80);
    wr(`ISR_SHIFT_DATA_REG, 8'h55);
    rd(`ISR_SHIFT_DATA_REG, 8'h00, 8'hff);
    base = irq_cnt;
    agent_u.put_byte(own ^ 8'h02);
    agent_u.stop_c;
    w = 0;
    while (sda_oe !== 1'b1 && w < 100) begin
      @(negedge sys_clk);
      w = w + 1;
    end
    #1 check({7'h00, sda_oe}, 8'h01, 8'h01);
    w = irq_cnt - base;
    check(w[7:0], 8'h01, 8'hff);
    rd(`ISR_BUS_STATUS_REG, 8'h80, 8'h80);
    check({6'h00, scl_oe, sda_oe}, 8'h03, 8'h03);
    wr(`ISR_BUS_CONTROL_REG, 8'h90);
    wr(`ISR_SHIFT_DATA_REG, own ^ 8'h02);
    rd(`ISR_SHIFT_DATA_REG, own ^ 8'h02, 8'hff);
    rd(`ISR_BUS_STATUS_REG, 8'h80, 8'h80);
    repeat (20) @(posedge sys_clk);
    check({6'h00, scl_oe, sda_oe}, 8'h03, 8'h03);
    check({6'h00, scl_out, sda_out}, 8'h00, 8'h03);
    $display("test 5 done");
    tally_and_finish;
  end
endmodule
